//--- common/wlsc_pkg.sv
// Package with constants and state types of the wake-latch sensor-supply control block
package wlsc_pkg;
	// ------------------------------------------------------------
	// Timing figures in their own units
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int SOFT_START_US = 1000;      // Soft-start of sensor supply, 1 ms typical low end
	localparam int KEY_FILTER_US = 7500;      // Key wake filter, 7.5 ms least
	localparam int BUS_FILTER_US = 7500;      // Bus wake filter, same deglitch used here
	localparam int STRETCH_SHORT_US = 1400;   // Hold stretch with pin grounded
	localparam int STRETCH_LONG_US = 4500;    // Hold stretch with 22 kOhm
	// ------------------------------------------------------------
	// Derived cycle counts (least times round up)
	// ------------------------------------------------------------
	localparam int SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
	localparam int KEY_FILTER_CYC = KEY_FILTER_US * CLK_MHZ;
	localparam int BUS_FILTER_CYC = BUS_FILTER_US * CLK_MHZ;
	localparam int STRETCH_SHORT_CYC = STRETCH_SHORT_US * CLK_MHZ;
	localparam int STRETCH_LONG_CYC = STRETCH_LONG_US * CLK_MHZ;
	localparam int CNT_W = 20;
	// ------------------------------------------------------------
	// Bit positions and reset values
	// ------------------------------------------------------------
	localparam int SENS_ON_BIT = 0;           // Enable bit in sensor_ctrl_reg
	localparam int PWR_HOLD_BIT = 4;          // key_power_hold in safety_function_cfg
	localparam int KEY_STAT_BIT = 0;          // Filtered key level in device_state_reg
	localparam int OT_FLAG_BIT = 2;           // Overtemp flag in safety status
	localparam logic [7:0] CTRL_RST = 8'h00;
	// ------------------------------------------------------------
	// Device state machine
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		WLSC_ST_STANDBY = 5'b00001,
		WLSC_ST_RESET = 5'b00010,
		WLSC_ST_DIAG = 5'b00100,
		WLSC_ST_ACTIVE = 5'b01000,
		WLSC_ST_SAFE = 5'b10000
	} wlsc_state_t;
endpackage

//--- rtl/wlsc_deglitch.sv
// Level deglitch filter: output follows input after it stays stable
`timescale 1ns/1ps
module wlsc_deglitch #(
	parameter int FILTER_CYC = wlsc_pkg::KEY_FILTER_CYC
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic raw_in,
	output logic filt_out
);
	import wlsc_pkg::*;
	logic [CNT_W-1:0] cnt_reg;
	logic filt_reg;
	// ------------------------------------------------------------
	// Stability counter
	// ------------------------------------------------------------
	// Counter restarts whenever input equals output, so short glitches never pass
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= '0;
			filt_reg <= 1'b0;
		end else if (raw_in == filt_reg) begin
			cnt_reg <= '0;
		end else if (cnt_reg >= CNT_W'(FILTER_CYC - 1)) begin
			cnt_reg <= '0;
			filt_reg <= raw_in;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
	assign filt_out = filt_reg;
endmodule

//--- rtl/wlsc_timer.sv
// One-shot cycle timer: start loads a terminal count, done pulses at expiry
`timescale 1ns/1ps
module wlsc_timer (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic start,
	input wire logic abort,
	input wire logic [wlsc_pkg::CNT_W-1:0] term_cnt,
	output logic busy,
	output logic done
);
	import wlsc_pkg::*;
	logic [CNT_W-1:0] cnt_reg;
	logic busy_reg;
	logic done_reg;
	// ------------------------------------------------------------
	// Countdown
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (abort) begin
				busy_reg <= 1'b0;
			end else if (start) begin
				cnt_reg <= term_cnt;
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (cnt_reg <= CNT_W'(1)) begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - 1'b1;
				end
			end
		end
	end
	assign busy = busy_reg;
	assign done = done_reg;
endmodule

//--- rtl/wlsc_ctrl.sv
// Control logic: sensor supply, wake filtering, power hold, standby and MCU reset stretch
`timescale 1ns/1ps
module wlsc_ctrl #(
	parameter int SOFT_CYC = wlsc_pkg::SOFT_START_CYC,
	parameter int KEY_CYC = wlsc_pkg::KEY_FILTER_CYC,
	parameter int BUS_CYC = wlsc_pkg::BUS_FILTER_CYC,
	parameter int STR_SHORT = wlsc_pkg::STRETCH_SHORT_CYC,
	parameter int STR_LONG = wlsc_pkg::STRETCH_LONG_CYC,
	parameter bit POST_RUN_RESET_EN = 1'b1
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic track_ref_input,
	input wire logic rails_ramped,
	input wire logic io_rail_ok,
	input wire logic core_rail_ok,
	input wire logic hold_stretch_pin,
	input wire logic key_wake_input,
	input wire logic bus_wake_input,
	input wire logic sensor_overtemp,
	input wire logic sensor_supply_low,
	input wire logic sensor_supply_high,
	input wire logic pump_level_high,
	input wire logic pump_level_low,
	input wire logic selftest_run,
	input wire logic diag_exit,
	input wire logic sensor_on_wr,
	input wire logic sensor_on_val,
	input wire logic safety_cfg_wr,
	input wire logic safety_cfg_val,
	input wire logic safety_stat_rd,
	input wire logic bus_standby_cmd,
	output logic track_mode,
	output logic sensor_supply_on_bit,
	output logic sensor_soft_start,
	output logic sensor_feedback,
	output logic overtemp_flag,
	output logic analog_selftest_error,
	output logic pump_high_flag,
	output logic pump_run,
	output logic key_stat,
	output logic key_power_hold,
	output logic bus_wake_held,
	output logic mcu_hold_low,
	output logic [4:0] dev_state
);
	import wlsc_pkg::*;
	wlsc_state_t state_reg;
	wlsc_state_t state_next;
	logic key_filt;
	logic bus_filt;
	logic key_filt_d_reg;
	logic track_reg;
	logic track_done_reg;
	logic on_reg;
	logic ot_reg;
	logic abist_reg;
	logic pump_reg;
	logic hold_reg;
	logic bus_held_reg;
	logic fb_reg;
	logic mcu_hold_low_reg;
	logic rails_good;
	logic stretch_busy;
	logic stretch_done;
	logic stretch_start;
	logic soft_busy;
	logic soft_done;
	logic soft_start;
	logic wake_any;
	logic key_rise;
	logic sleep_req;
	logic [CNT_W-1:0] stretch_cnt;

	// ------------------------------------------------------------
	// Wake filters
	// ------------------------------------------------------------
	// key wake deglitch
	wlsc_deglitch #(.FILTER_CYC(KEY_CYC)) u_key_filt (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.raw_in(key_wake_input),
		.filt_out(key_filt)
	);
	wlsc_deglitch #(.FILTER_CYC(BUS_CYC)) u_bus_filt (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.raw_in(bus_wake_input),
		.filt_out(bus_filt)
	);
	assign wake_any = key_filt | bus_filt;
	assign key_rise = key_filt & ~key_filt_d_reg;

	// Edge history of the filtered key level
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			key_filt_d_reg <= 1'b0;
		end else begin
			key_filt_d_reg <= key_filt;
		end
	end

	// ------------------------------------------------------------
	// Tracking mode latch
	// ------------------------------------------------------------
	// comparator level sampled synchronously; caught once at first ramp
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			track_reg <= 1'b0;
			track_done_reg <= 1'b0;
		end else if (!track_done_reg && rails_ramped) begin
			track_reg <= track_ref_input;
			track_done_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Reset stretch of the MCU reset
	// ------------------------------------------------------------
	assign rails_good = io_rail_ok & core_rail_ok;
	// grounded pin gives short stretch, resistor gives long
	assign stretch_cnt = hold_stretch_pin ? CNT_W'(STR_LONG) : CNT_W'(STR_SHORT);
	assign stretch_start = rails_good & ~stretch_busy & ~stretch_done;

	wlsc_timer u_stretch (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.start(stretch_start),
		.abort(~rails_good | (state_reg != WLSC_ST_RESET)), // No stale count outlives RESET
		.term_cnt(stretch_cnt),
		.busy(stretch_busy),
		.done(stretch_done)
	);

	// reset low until rails good plus stretch; expiry in RESET releases it
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mcu_hold_low_reg <= 1'b0;
		end else if (stretch_done && rails_good) begin
			mcu_hold_low_reg <= 1'b1;
		end else if (!rails_good || state_reg == WLSC_ST_RESET || state_reg == WLSC_ST_STANDBY) begin
			mcu_hold_low_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Device state machine
	// ------------------------------------------------------------
	// Sleep requested outside RESET when hold cleared with key low and no bus wake held, or by standby command while bus wake held
	assign sleep_req = (bus_standby_cmd & bus_held_reg) |
		(state_reg != WLSC_ST_RESET && !hold_reg && !key_filt && !bus_held_reg);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			WLSC_ST_STANDBY: begin
				if (wake_any) begin
					state_next = WLSC_ST_RESET;
				end
			end
			WLSC_ST_RESET: begin
				if (stretch_done && rails_good) begin
					state_next = WLSC_ST_DIAG;
				end
			end
			WLSC_ST_DIAG: begin
				// supply fault during self-test forces SAFE
				if (selftest_run && (sensor_supply_low || sensor_supply_high)) begin
					state_next = WLSC_ST_SAFE;
				end else if (diag_exit) begin
					state_next = WLSC_ST_ACTIVE;
				end
			end
			WLSC_ST_ACTIVE: begin
				// optional reset on key wake while held
				if (POST_RUN_RESET_EN && hold_reg && key_rise) begin
					state_next = WLSC_ST_RESET;
				end
			end
			WLSC_ST_SAFE: begin
				state_next = WLSC_ST_SAFE;
			end
			default: begin
				state_next = WLSC_ST_STANDBY;
			end
		endcase
		// standby entry bounces straight to RESET when wake is active
		if (state_reg != WLSC_ST_STANDBY && sleep_req) begin
			state_next = wake_any ? WLSC_ST_RESET : WLSC_ST_STANDBY;
		end
	end

	// State register; power-on starts in RESET
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= WLSC_ST_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// Analog self-test error flag, sticky until power-on
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			abist_reg <= 1'b0;
		end else if (state_reg == WLSC_ST_DIAG && selftest_run &&
			(sensor_supply_low || sensor_supply_high)) begin
			abist_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Sensor supply enable and overtemperature
	// ------------------------------------------------------------
	// power-on reset, overtemperature, a standby entry or an MCU write of 0 clears the enable
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			on_reg <= CTRL_RST[SENS_ON_BIT];
		end else if (sensor_overtemp) begin
			on_reg <= 1'b0;
		end else if (state_next == WLSC_ST_STANDBY && state_reg != WLSC_ST_STANDBY) begin
			on_reg <= 1'b0;
		end else if (sensor_on_wr && mcu_hold_low_reg && !(ot_reg && sensor_on_val)) begin
			// MCU writes after reset release; a write of 1 is blocked while flag stands
			on_reg <= sensor_on_val;
		end
	end

	// Overtemp flag: a new event in the read cycle wins over the clear
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ot_reg <= 1'b0;
		end else if (sensor_overtemp) begin
			ot_reg <= 1'b1;
		end else if (safety_stat_rd) begin
			ot_reg <= 1'b0;
		end
	end

	// soft-start on enable, feedback reached at its end
	assign soft_start = on_reg & ~fb_reg & ~soft_busy & ~soft_done;
	wlsc_timer u_soft (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.start(soft_start),
		.abort(~on_reg),
		.term_cnt(CNT_W'(SOFT_CYC)),
		.busy(soft_busy),
		.done(soft_done)
	);

	// Feedback ramped flag follows soft-start completion
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fb_reg <= 1'b0;
		end else if (!on_reg) begin
			fb_reg <= 1'b0;
		end else if (soft_done) begin
			fb_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Charge pump hysteresis
	// ------------------------------------------------------------
	// set when high enough, clear below threshold
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pump_reg <= 1'b0;
		end else if (pump_level_high) begin
			pump_reg <= 1'b1;
		end else if (pump_level_low) begin
			pump_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Power hold and bus wake latch
	// ------------------------------------------------------------
	// writes only in DIAG; bus wake clears hold
	// while hold set, key fall has no effect
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_reg <= 1'b0;
		end else if (bus_filt && !bus_held_reg) begin
			hold_reg <= 1'b0;
		end else if (safety_cfg_wr && state_reg == WLSC_ST_DIAG) begin
			// MCU sets hold to stay powered
			hold_reg <= safety_cfg_val;
		end
	end

	// filtered bus wake held until the standby command
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_held_reg <= 1'b0;
		end else if (bus_filt) begin
			bus_held_reg <= 1'b1;
		end else if (bus_standby_cmd) begin
			bus_held_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign track_mode = track_reg;
	assign sensor_supply_on_bit = on_reg;
	assign sensor_soft_start = soft_busy;
	assign sensor_feedback = fb_reg;
	assign overtemp_flag = ot_reg;
	assign analog_selftest_error = abist_reg;
	assign pump_high_flag = pump_reg;
	assign pump_run = ~pump_reg;
	assign key_stat = key_filt;
	assign key_power_hold = hold_reg;
	assign bus_wake_held = bus_held_reg;
	assign mcu_hold_low = mcu_hold_low_reg;   // High means MCU released
	assign dev_state = state_reg;
endmodule

//--- test/wlsc_ctrl_chk.sv
// Concurrent checks on the control block ports
`timescale 1ns/1ps
module wlsc_ctrl_chk #(
	parameter int KEY_CYC = 8,
	parameter int BUS_CYC = 8,
	parameter int STR_SHORT = 16,
	parameter int STR_LONG = 40
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic rails_ramped,
	input wire logic io_rail_ok,
	input wire logic core_rail_ok,
	input wire logic hold_stretch_pin,
	input wire logic key_wake_input,
	input wire logic bus_wake_input,
	input wire logic sensor_overtemp,
	input wire logic sensor_supply_low,
	input wire logic sensor_supply_high,
	input wire logic pump_level_high,
	input wire logic pump_level_low,
	input wire logic selftest_run,
	input wire logic sensor_on_wr,
	input wire logic sensor_on_val,
	input wire logic track_mode,
	input wire logic sensor_supply_on_bit,
	input wire logic sensor_soft_start,
	input wire logic overtemp_flag,
	input wire logic analog_selftest_error,
	input wire logic pump_high_flag,
	input wire logic pump_run,
	input wire logic key_stat,
	input wire logic key_power_hold,
	input wire logic bus_wake_held,
	input wire logic mcu_hold_low,
	input wire logic [4:0] dev_state
);
	import wlsc_pkg::*;
	logic [7:0] ok_reg;
	logic [7:0] key_reg;
	logic [7:0] bus_reg;
	function automatic logic [7:0] sat(input logic [7:0] v);
		return (v == 8'hFF) ? v : v + 8'h01;
	endfunction
	// Run lengths of good rails and high wake levels; saturate so long runs stay valid
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ok_reg <= 8'h00;
			key_reg <= 8'h00;
			bus_reg <= 8'h00;
		end else begin
			ok_reg <= (io_rail_ok && core_rail_ok) ? sat(ok_reg) : 8'h00;
			key_reg <= key_wake_input ? sat(key_reg) : 8'h00;
			bus_reg <= bus_wake_input ? sat(bus_reg) : 8'h00;
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_soft_run;
		sensor_soft_start [*4];
	endsequence
	sequence s_to_safe;
		##[0:3] (dev_state == WLSC_ST_SAFE);
	endsequence
	property p_release;
		$rose(mcu_hold_low) |-> ok_reg >= (hold_stretch_pin ? STR_LONG : STR_SHORT);
	endproperty
	property p_on_cause;
		$rose(sensor_supply_on_bit) |-> $past(sensor_on_wr && sensor_on_val && mcu_hold_low);
	endproperty
	property p_soft;
		$rose(sensor_supply_on_bit) |-> ##[1:3] s_soft_run;
	endproperty
	property p_ot;
		sensor_overtemp |=> overtemp_flag && !sensor_supply_on_bit;
	endproperty
	property p_track;
		$past(rails_ramped, 3) |-> $stable(track_mode);
	endproperty
	property p_pump;
		$changed(pump_high_flag) |->
			$past(pump_high_flag ? pump_level_low : pump_level_high) && pump_run != pump_high_flag;
	endproperty
	property p_key_filt;
		$rose(key_stat) |-> key_reg >= KEY_CYC - 1;
	endproperty
	property p_bus_filt;
		$rose(bus_wake_held) |-> bus_reg >= BUS_CYC - 1;
	endproperty
	property p_sleep;
		$rose(dev_state == WLSC_ST_STANDBY) |-> !$past(key_power_hold);
	endproperty
	property p_abist;
		$rose(analog_selftest_error) |->
			$past(selftest_run && (sensor_supply_low || sensor_supply_high)) ##0 s_to_safe;
	endproperty
	a_release: assert property (p_release) else $error("reset released early");
	a_on_cause: assert property (p_on_cause) else $error("enable without cause");
	a_soft: assert property (p_soft) else $error("no soft start");
	a_ot: assert property (p_ot) else $error("overtemp kept supply on");
	a_track: assert property (p_track) else $error("mode changed after ramp");
	a_pump: assert property (p_pump) else $error("pump flag wrong");
	a_key_filt: assert property (p_key_filt) else $error("key not filtered");
	a_bus_filt: assert property (p_bus_filt) else $error("bus wake not filtered");
	a_sleep: assert property (p_sleep) else $error("sleep with hold set");
	a_abist: assert property (p_abist) else $error("self-test error path wrong");
endmodule
bind wlsc_ctrl wlsc_ctrl_chk #(
	.KEY_CYC(KEY_CYC),
	.BUS_CYC(BUS_CYC),
	.STR_SHORT(STR_SHORT),
	.STR_LONG(STR_LONG)
) wlsc_ctrl_chk_i (.*);

//--- test/wlsc_mcu.sv
// Microcontroller model driving the command strobes of the control block
`timescale 1ns/1ps
module wlsc_mcu (
	input wire logic sys_clk,
	input wire logic mcu_hold_low,
	input wire logic key_wake_input,
	input wire logic bus_wake_input,
	output logic sensor_on_wr,
	output logic sensor_on_val,
	output logic safety_cfg_wr,
	output logic safety_cfg_val,
	output logic safety_stat_rd,
	output logic bus_standby_cmd,
	output logic diag_exit
);
	// Idle strobes low at time zero
	initial begin
		{diag_exit, bus_standby_cmd, safety_stat_rd, safety_cfg_wr, sensor_on_wr} = 5'h00;
		sensor_on_val = 1'h0;
		safety_cfg_val = 1'h0;
	end
	// One-cycle strobe; value lines flip afterwards so stale data is never trusted
	task automatic cmd(input logic [2:0] sel, input logic v);
		@(negedge sys_clk);
		{diag_exit, bus_standby_cmd, safety_stat_rd, safety_cfg_wr, sensor_on_wr} <= 5'h01 << sel;
		sensor_on_val <= v;
		safety_cfg_val <= v;
		@(negedge sys_clk);
		{diag_exit, bus_standby_cmd, safety_stat_rd, safety_cfg_wr, sensor_on_wr} <= 5'h00;
		sensor_on_val <= ~v;
		safety_cfg_val <= ~v;
	endtask
	task automatic on(input logic v);
		for (int i = 0; i < 500 && mcu_hold_low !== 1'h1; i++) @(negedge sys_clk);
		cmd(3'h0, v);
	endtask
	task automatic reenable();
		cmd(3'h2, 1'h0);
		on(1'h1);
	endtask
	task automatic standby();
		for (int i = 0; i < 500 && (key_wake_input || bus_wake_input); i++) @(negedge sys_clk);
		cmd(3'h3, 1'h1);
	endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the control block
`timescale 1ns/1ps
module testbench;
	import wlsc_pkg::*;
	localparam int SOFT = 20;
	localparam int KEYC = 8;
	localparam int BUSC = 8;
	localparam int SSHORT = 16;
	localparam int SLONG = 40;
	logic sys_clk, arst_n, track_ref_input, rails_ramped, io_rail_ok, core_rail_ok;
	logic hold_stretch_pin, key_wake_input, bus_wake_input, sensor_overtemp;
	logic sensor_supply_low, sensor_supply_high, pump_level_high, pump_level_low, selftest_run;
	logic sensor_on_wr, sensor_on_val, safety_cfg_wr, safety_cfg_val, safety_stat_rd;
	logic bus_standby_cmd, diag_exit, track_mode, sensor_supply_on_bit, sensor_soft_start;
	logic sensor_feedback, overtemp_flag, analog_selftest_error, pump_high_flag, pump_run;
	logic key_stat, key_power_hold, bus_wake_held, mcu_hold_low;
	logic [4:0] dev_state;
	int failures, checks, n;
	wlsc_ctrl #(.SOFT_CYC(SOFT), .KEY_CYC(KEYC), .BUS_CYC(BUSC), .STR_SHORT(SSHORT),
		.STR_LONG(SLONG)) wlsc_ctrl_i (.*);
	wlsc_mcu wlsc_mcu_i (.*);
	// Free-running 125 MHz clock
	initial begin
		sys_clk = 1'h0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(negedge sys_clk);
	endtask
	// Bounded wait for a state; running out ends the run
	task automatic wait_state(input logic [4:0] s);
		int i;
		for (i = 0; i < 300 && dev_state !== s; i++) tick(1);
		chk(dev_state, s);
		if (i == 300) end_of_test();
	endtask
	// Power-on with a chosen stretch pin and mode level, then measure the release
	task automatic power_up(input logic p);
		int lim;
		lim = p ? SLONG : SSHORT;
		@(negedge sys_clk);
		arst_n = 1'h0;
		{rails_ramped, io_rail_ok, core_rail_ok} = 3'h0;
		hold_stretch_pin = p;
		track_ref_input = p;
		key_wake_input = 1'h1; // Wake held so the device stays up after reset
		tick(3);
		arst_n = 1'h1;
		chk({dev_state, mcu_hold_low, sensor_supply_on_bit}, {WLSC_ST_RESET, 2'h0});
		{rails_ramped, io_rail_ok, core_rail_ok} = 3'h7;
		wlsc_mcu_i.cmd(3'h0, 1'h1);
		for (n = 2; n < 300 && mcu_hold_low !== 1'h1; n++) tick(1);
		chk(n >= lim && n <= lim + 6, 1);
		if (n == 300) end_of_test();
		track_ref_input = ~p;
		tick(3);
		chk({track_mode, sensor_supply_on_bit}, {p, 1'h0});
		chk(dev_state, WLSC_ST_DIAG);
	endtask
	initial begin
		{arst_n, track_ref_input, rails_ramped, io_rail_ok, core_rail_ok} = 5'h00;
		{hold_stretch_pin, key_wake_input, bus_wake_input, sensor_overtemp} = 4'h0;
		{sensor_supply_low, sensor_supply_high, pump_level_high, pump_level_low} = 4'h0;
		selftest_run = 1'h0;
		failures = 0;
		checks = 0;
		power_up(1'h1);
		power_up(1'h0);
		// Enable, soft start, then feedback
		wlsc_mcu_i.on(1'h1);
		tick(3);
		chk({sensor_supply_on_bit, sensor_soft_start, sensor_feedback}, 3'h6);
		for (n = 0; n < 100 && sensor_feedback !== 1'h1; n++) tick(1);
		chk(n >= SOFT - 5 && n <= SOFT + 3, 1);
		if (n == 100) end_of_test();
		// Overtemperature shutdown and the guarded re-enable
		sensor_overtemp = 1'h1;
		tick(1);
		sensor_overtemp = 1'h0;
		tick(1);
		chk({sensor_supply_on_bit, overtemp_flag, mcu_hold_low}, 3'h3);
		wlsc_mcu_i.on(1'h1);
		tick(1);
		chk(sensor_supply_on_bit, 1'h0);
		wlsc_mcu_i.reenable();
		tick(1);
		chk({sensor_supply_on_bit, overtemp_flag}, 2'h2);
		// Pump flag holds between the two levels
		pump_level_high = 1'h1;
		tick(1);
		pump_level_high = 1'h0;
		tick(2);
		chk({pump_high_flag, pump_run}, 2'h2);
		pump_level_low = 1'h1;
		tick(1);
		pump_level_low = 1'h0;
		tick(1);
		chk({pump_high_flag, pump_run}, 2'h1);
		// Key stays high from power-up; a short low glitch must not pass the filter
		key_wake_input = 1'h0;
		tick(KEYC - 2);
		chk(key_stat, 1'h1);
		key_wake_input = 1'h1;
		tick(KEYC + 3);
		chk({key_stat, dev_state}, {1'h1, WLSC_ST_DIAG});
		// Power hold set in DIAG, locked elsewhere, post-run then key wake
		wlsc_mcu_i.cmd(3'h1, 1'h1);
		tick(1);
		chk(key_power_hold, 1'h1);
		wlsc_mcu_i.cmd(3'h4, 1'h1);
		tick(1);
		chk(dev_state, WLSC_ST_ACTIVE);
		wlsc_mcu_i.cmd(3'h1, 1'h0);
		tick(1);
		chk(key_power_hold, 1'h1);
		key_wake_input = 1'h0;
		tick(KEYC + 3);
		chk({key_stat, key_power_hold, dev_state}, {2'h1, WLSC_ST_ACTIVE});
		key_wake_input = 1'h1;
		wait_state(WLSC_ST_RESET);
		chk(sensor_supply_on_bit, 1'h1);
		wait_state(WLSC_ST_DIAG);
		// Bus wake filtered, held, clears the hold; standby by command
		wlsc_mcu_i.cmd(3'h1, 1'h1);
		bus_wake_input = 1'h1;
		tick(BUSC - 2);
		bus_wake_input = 1'h0;
		tick(2);
		chk({bus_wake_held, key_power_hold}, 2'h1);
		bus_wake_input = 1'h1;
		tick(BUSC + 4);
		bus_wake_input = 1'h0;
		chk({bus_wake_held, key_power_hold}, 2'h2);
		// Standby command while key is still high bounces through RESET
		wlsc_mcu_i.cmd(3'h3, 1'h1);
		wait_state(WLSC_ST_RESET);
		chk({sensor_supply_on_bit, bus_wake_held}, 2'h3);
		wait_state(WLSC_ST_DIAG);
		key_wake_input = 1'h0;
		tick(KEYC + 3);
		chk(dev_state, WLSC_ST_DIAG);
		wlsc_mcu_i.standby();
		wait_state(WLSC_ST_STANDBY);
		chk(sensor_supply_on_bit, 1'h0);
		// Key wake, then a supply fault during self-test
		key_wake_input = 1'h1;
		wait_state(WLSC_ST_RESET);
		selftest_run = 1'h1;
		sensor_supply_high = 1'h1;
		wait_state(WLSC_ST_SAFE);
		chk(analog_selftest_error, 1'h1);
		end_of_test();
	end
endmodule
